/* include/csor_pkg.sv */
// shared constants and types for the core status and option register bank
package csor_pkg;

	// ****************************************
	// file register decode (9-bit data address)
	// ****************************************
	localparam logic [6:0] STATUS_LOW7 = 7'h03;
	localparam logic [7:0] OPTION_LOW8 = 8'h81;
	localparam logic [8:0] STATUS_IDX = 9'h003;
	localparam logic [8:0] OPTION_IDX = 9'h081;
	localparam int ADDR_W = 12;
	localparam int IDX_LSB = 2;
	localparam int IDX_MSB = 10;
	localparam logic [1:0] IDX_LSB_ZERO = 2'h0;

	// ****************************************
	// status register fields
	// ****************************************
	localparam int STS_INDIRECT_BANK = 7;
	localparam int STS_DIRECT_BANK_HI = 6;
	localparam int STS_DIRECT_BANK_LO = 5;
	localparam int STS_TIMEOUT = 4;
	localparam int STS_POWER_DOWN = 3;
	localparam int STS_ZERO = 2;
	localparam int STS_DIGIT_CARRY = 1;
	localparam int STS_CARRY = 0;
	localparam logic [7:0] STATUS_RESET = 8'h18;
	// the time-out and power-down bits are never written by software
	localparam logic [7:0] STATUS_WR_MASK = 8'he7;

	// ****************************************
	// option register fields
	// ****************************************
	localparam int OPT_PULLUP_DIS = 7;
	localparam int OPT_INT_EDGE = 6;
	localparam int OPT_T0_SRC = 5;
	localparam int OPT_T0_EDGE = 4;
	localparam int OPT_PSC_ASSIGN = 3;
	localparam int OPT_RATE_HI = 2;
	localparam int OPT_RATE_LO = 0;
	localparam logic [7:0] OPTION_RESET = 8'hff;

	// ****************************************
	// prescaler, postscaler, pins
	// ****************************************
	localparam int PSC_W = 8;
	localparam int POST_W = 16;
	localparam logic [15:0] WDT_POST_TOP_DEFAULT = 16'hffff;
	localparam int PORTA_W = 6;
	localparam int HALF_W = 4;

	// ****************************************
	// operation reported by the core for flag update
	// ****************************************
	typedef enum logic [2:0] {
		ALU_NONE = 3'h0,
		ALU_ADD = 3'h1,
		ALU_SUB = 3'h2,
		ALU_ROT_RIGHT = 3'h3,
		ALU_ROT_LEFT = 3'h4,
		ALU_LOGIC = 3'h5
	} csor_alu_op_type;

endpackage : csor_pkg

/* logic/csor_core_regs.sv */
// core status and option registers with flag logic, prescaler and watchdog postscaler
//
// Functional notes
// - indirect bank bit picks banks 2,3 or 0,1
// - direct bank field picks one of four banks
// - time-out set at power-up, clear-watchdog, sleep
// - watchdog expiry clears time-out flag
// - power-down set at power-up and clear-watchdog
// - sleep clears power-down flag
// - zero flag shows zero result
// - digit carry is carry from bit 3
// - carry is carry out of bit 7
// - subtract adds two's complement, borrow inverted
// - rotates load carry with bit shifted out
// - assignment bit gives prescaler to watchdog or timer0
// - watchdog path has dedicated 16-bit postscaler
// - status decodes in all four banks
// - option decodes at 81h and 181h
// - flag logic beats written flag bits
// - time-out and power-down ignore software writes
`timescale 1ns/1ps

module csor_core_regs
	import csor_pkg::*;
#(
	parameter logic [15:0] WDT_POST_TOP = csor_pkg::WDT_POST_TOP_DEFAULT
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [csor_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic core_wr_en,
	input wire logic [8:0] core_wr_addr,
	input wire logic [7:0] core_wr_data,
	input wire csor_pkg::csor_alu_op_type alu_op,
	input wire logic [7:0] alu_a,
	input wire logic [7:0] alu_b,
	input wire logic clear_watchdog_instruction,
	input wire logic sleep_instruction,
	input wire logic watchdog_enable,
	input wire logic watchdog_tick,
	input wire logic instr_cycle_tick,
	input wire logic timer0_clock_pin,
	input wire logic ext_interrupt_pin,
	input wire logic [csor_pkg::PORTA_W-1:0] port_a_pullup_mask,
	input wire logic [6:0] direct_addr,
	input wire logic [7:0] indirect_ptr,
	output logic [8:0] direct_data_addr,
	output logic [8:0] indirect_data_addr,
	output logic [7:0] core_status_flags,
	output logic [7:0] timer_prescale_options,
	output logic [csor_pkg::PORTA_W-1:0] port_a_pullup_en,
	output logic timer0_increment,
	output logic watchdog_timeout,
	output logic ext_int_edge_event
);
	import csor_pkg::*;

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [7:0] status;
		logic [7:0] option;
		logic [PSC_W-1:0] psc_cnt;
		logic [POST_W-1:0] post_cnt;
		logic [1:0] t0ck_sync;
		logic [1:0] int_sync;
		logic t0ck_prev;
		logic int_prev;
		logic timer0_inc;
		logic wdt_timeout;
		logic int_edge;
		logic [PORTA_W-1:0] pullup_en;
		logic [31:0] rdata;
	} csor_state_type;

	csor_state_type state_q;
	csor_state_type state_d;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic is_status(input logic [8:0] a);
		is_status = (a[6:0] == STATUS_LOW7);
	endfunction : is_status

	function automatic logic is_option(input logic [8:0] a);
		is_option = (a[7:0] == OPTION_LOW8);
	endfunction : is_option

	// returns {carry, digit carry, sum}
	function automatic logic [9:0] add_flags(input logic [7:0] a, input logic [7:0] b, input logic cin);
		logic [8:0] full;
		logic [HALF_W:0] low;
		full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
		low = {1'b0, a[HALF_W-1:0]} + {1'b0, b[HALF_W-1:0]} + {4'h0, cin};
		add_flags = {full[8], low[HALF_W], full[7:0]};
	endfunction : add_flags

	// a prescaler of ratio 2^shift fires when the low shift bits wrap to zero
	function automatic logic psc_hit(input logic [PSC_W-1:0] cnt, input logic [3:0] shift);
		logic [PSC_W:0] mask;
		mask = ({{PSC_W{1'b0}}, 1'b1} << shift) - {{PSC_W{1'b0}}, 1'b1};
		psc_hit = ((cnt & mask[PSC_W-1:0]) == {PSC_W{1'b0}});
	endfunction : psc_hit

	// merge a write into the status register, keeping the read-only bits
	function automatic logic [7:0] status_write(input logic [7:0] cur, input logic [7:0] wr);
		status_write = (wr & STATUS_WR_MASK) | (cur & ~STATUS_WR_MASK);
	endfunction : status_write

	// ****************************************
	// apb decode
	// ****************************************
	logic [8:0] apb_idx;
	logic apb_aligned;
	logic apb_status;
	logic apb_option;
	logic apb_hit;
	logic apb_wr;

	// the word index is the 9-bit file address, so the bank mirrors appear on the bus too
	assign apb_idx = paddr[IDX_MSB:IDX_LSB];
	assign apb_aligned = (paddr[IDX_LSB-1:0] == IDX_LSB_ZERO) && !paddr[ADDR_W-1];
	assign apb_status = apb_aligned && is_status(apb_idx);
	assign apb_option = apb_aligned && is_option(apb_idx);
	assign apb_hit = apb_status || apb_option;
	assign apb_wr = psel && penable && pwrite && apb_hit;
	// every register answers in its access phase, so no wait states are needed
	assign pready = 1'b1;
	// unmapped or misaligned words fail loudly instead of aliasing onto a register
	assign pslverr = psel && penable && !apb_hit;

	// ****************************************
	// next state
	// ****************************************
	logic [9:0] arith;
	logic t0_src_tick;
	logic t0_pin_edge;
	logic psc_to_wdt;
	logic psc_in;
	logic [PSC_W-1:0] psc_next;
	logic [3:0] rate;
	logic psc_out;
	logic t0_tick;
	logic wdt_stage;
	logic wdt_expire;

	always_comb begin
		state_d = state_q;
		arith = 10'h000;
		rate = {1'b0, state_q.option[OPT_RATE_HI:OPT_RATE_LO]};
		psc_to_wdt = state_q.option[OPT_PSC_ASSIGN];

		// synchronisers: the first stage feeds only the second
		// the pins are asynchronous, so two stages guard the edge logic from metastability
		state_d.t0ck_sync = {state_q.t0ck_sync[0], timer0_clock_pin};
		state_d.int_sync = {state_q.int_sync[0], ext_interrupt_pin};
		state_d.t0ck_prev = state_q.t0ck_sync[1];
		state_d.int_prev = state_q.int_sync[1];

		// external interrupt edge
		if (state_q.option[OPT_INT_EDGE]) begin
			state_d.int_edge = state_q.int_sync[1] && !state_q.int_prev;
		end else begin
			state_d.int_edge = !state_q.int_sync[1] && state_q.int_prev;
		end

		// timer0 source
		if (state_q.option[OPT_T0_EDGE]) begin
			t0_pin_edge = !state_q.t0ck_sync[1] && state_q.t0ck_prev;
		end else begin
			t0_pin_edge = state_q.t0ck_sync[1] && !state_q.t0ck_prev;
		end
		t0_src_tick = state_q.option[OPT_T0_SRC] ? t0_pin_edge : instr_cycle_tick;

		// shared prescaler
		// the count survives option writes, so a reassignment may cut one period short
		psc_in = psc_to_wdt ? (watchdog_tick && watchdog_enable) : t0_src_tick;
		psc_next = state_q.psc_cnt + {{(PSC_W-1){1'b0}}, 1'b1};
		if (psc_to_wdt) begin
			psc_out = psc_in && psc_hit(psc_next, rate);
		end else begin
			psc_out = psc_in && psc_hit(psc_next, rate + 4'h1);
		end
		if (psc_in) begin
			state_d.psc_cnt = psc_next;
		end
		t0_tick = psc_to_wdt ? t0_src_tick : psc_out;
		wdt_stage = psc_to_wdt ? psc_out : (watchdog_tick && watchdog_enable);
		state_d.timer0_inc = t0_tick;

		// dedicated watchdog postscaler
		// expiry falls on the tick that finds the top count: a period is top plus one ticks
		wdt_expire = 1'b0;
		if (wdt_stage) begin
			if (state_q.post_cnt == WDT_POST_TOP) begin
				wdt_expire = 1'b1;
				state_d.post_cnt = {POST_W{1'b0}};
			end else begin
				state_d.post_cnt = state_q.post_cnt + {{(POST_W-1){1'b0}}, 1'b1};
			end
		end
		// restarting the watchdog also restarts the prescaler while it serves the watchdog
		if (clear_watchdog_instruction || sleep_instruction) begin
			wdt_expire = 1'b0;
			state_d.post_cnt = {POST_W{1'b0}};
			if (psc_to_wdt) begin
				state_d.psc_cnt = {PSC_W{1'b0}};
			end
		end
		state_d.wdt_timeout = wdt_expire;

		// register writes: core first, a bus write in the same cycle lands last
		if (core_wr_en && is_status(core_wr_addr)) begin
			state_d.status = status_write(state_q.status, core_wr_data);
		end
		if (core_wr_en && is_option(core_wr_addr)) begin
			state_d.option = core_wr_data;
		end
		if (apb_wr && apb_status) begin
			state_d.status = status_write(state_d.status, pwdata[7:0]);
		end
		if (apb_wr && apb_option) begin
			state_d.option = pwdata[7:0];
		end

		// reset-cause flags
		// set wins: a restart in the expiry cycle keeps the time-out flag high
		if (wdt_expire) begin
			state_d.status[STS_TIMEOUT] = 1'b0;
		end
		if (clear_watchdog_instruction) begin
			state_d.status[STS_TIMEOUT] = 1'b1;
			state_d.status[STS_POWER_DOWN] = 1'b1;
		end
		if (sleep_instruction) begin
			state_d.status[STS_TIMEOUT] = 1'b1;
			state_d.status[STS_POWER_DOWN] = 1'b0;
		end

		// alu flags are applied after any write, so they override written flag bits
		// the core reports at most one flag update per cycle
		case (alu_op)
			ALU_ADD: begin
				arith = add_flags(alu_a, alu_b, 1'b0);
				state_d.status[STS_CARRY] = arith[9];
				state_d.status[STS_DIGIT_CARRY] = arith[8];
				state_d.status[STS_ZERO] = (arith[7:0] == 8'h00);
			end
			ALU_SUB: begin
				// a - b as a + ~b + 1: the carries read as inverted borrows
				arith = add_flags(alu_a, ~alu_b, 1'b1);
				state_d.status[STS_CARRY] = arith[9];
				state_d.status[STS_DIGIT_CARRY] = arith[8];
				state_d.status[STS_ZERO] = (arith[7:0] == 8'h00);
			end
			ALU_ROT_RIGHT: begin
				state_d.status[STS_CARRY] = alu_a[0];
			end
			ALU_ROT_LEFT: begin
				state_d.status[STS_CARRY] = alu_a[7];
			end
			ALU_LOGIC: begin
				state_d.status[STS_ZERO] = (alu_a == 8'h00);
			end
			default: begin
				arith = 10'h000;
			end
		endcase

		// pull-ups
		// registered, so the enables follow a mask change one cycle late
		if (state_q.option[OPT_PULLUP_DIS]) begin
			state_d.pullup_en = {PORTA_W{1'b0}};
		end else begin
			state_d.pullup_en = port_a_pullup_mask;
		end

		// read data is captured in the setup cycle, ready for the access phase
		if (psel && !penable) begin
			state_d.rdata = 32'h0000_0000;
			if (apb_status) begin
				state_d.rdata = {24'h00_0000, state_q.status};
			end else if (apb_option) begin
				state_d.rdata = {24'h00_0000, state_q.option};
			end
		end
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// reset stands for power-up: time-out and power-down read 1
			state_q.status <= STATUS_RESET;
			state_q.option <= OPTION_RESET;
			state_q.psc_cnt <= {PSC_W{1'b0}};
			state_q.post_cnt <= {POST_W{1'b0}};
			state_q.t0ck_sync <= 2'h0;
			state_q.int_sync <= 2'h0;
			state_q.t0ck_prev <= 1'b0;
			state_q.int_prev <= 1'b0;
			state_q.timer0_inc <= 1'b0;
			state_q.wdt_timeout <= 1'b0;
			state_q.int_edge <= 1'b0;
			state_q.pullup_en <= {PORTA_W{1'b0}};
			state_q.rdata <= 32'h0000_0000;
		end else begin
			state_q <= state_d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	// bank bits come straight from the register; the low address bits are the core's own
	// combinational, so a bank change steers the very next data access
	assign indirect_data_addr = {state_q.status[STS_INDIRECT_BANK], indirect_ptr};
	assign direct_data_addr = {state_q.status[STS_DIRECT_BANK_HI:STS_DIRECT_BANK_LO], direct_addr};
	assign core_status_flags = state_q.status;
	assign timer_prescale_options = state_q.option;
	assign port_a_pullup_en = state_q.pullup_en;
	assign timer0_increment = state_q.timer0_inc;
	assign watchdog_timeout = state_q.wdt_timeout;
	assign ext_int_edge_event = state_q.int_edge;
	assign prdata = state_q.rdata;

endmodule : csor_core_regs

/* test/csor_monitor.sv */
// checker bound to the core status and option register bank
`timescale 1ns/1ps
module csor_monitor
	import csor_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire csor_pkg::csor_alu_op_type alu_op,
	input wire logic [7:0] alu_a,
	input wire logic [7:0] alu_b,
	input wire logic clear_watchdog_instruction,
	input wire logic sleep_instruction,
	input wire logic watchdog_tick,
	input wire logic [6:0] direct_addr,
	input wire logic [7:0] indirect_ptr,
	input wire logic [8:0] direct_data_addr,
	input wire logic [8:0] indirect_data_addr,
	input wire logic [7:0] core_status_flags,
	input wire logic watchdog_timeout
);
	// ****************************************
	// reference flag arithmetic
	// ****************************************
	logic sub;
	logic st_wr;
	logic [7:0] bx;
	logic [8:0] sum;
	logic [4:0] nib;
	logic [2:0] flags_q;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// subtract adds the complement plus one, so carries read as inverted borrows
	assign sub = alu_op == ALU_SUB;
	assign bx = sub ? ~alu_b : alu_b;
	assign sum = {1'b0, alu_a} + {1'b0, bx} + {8'h00, sub};
	assign nib = {1'b0, alu_a[3:0]} + {1'b0, bx[3:0]} + {4'h0, sub};
	assign st_wr = psel && penable && pwrite && !paddr[11] && paddr[8:0] == 9'h00c;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			flags_q <= 3'h0;
		else
			flags_q <= {sum[7:0] == 8'h00, nib[4], sum[8]};
	end
	a_arith_flags: assert property (alu_op inside {ALU_ADD, ALU_SUB} |=>
		core_status_flags[2:0] == flags_q) else $error("arith flags wrong");
	a_rot_right: assert property (alu_op == ALU_ROT_RIGHT |=>
		core_status_flags[0] == $past(alu_a[0])) else $error("rotate right carry wrong");
	a_rot_left: assert property (alu_op == ALU_ROT_LEFT |=>
		core_status_flags[0] == $past(alu_a[7])) else $error("rotate left carry wrong");
	a_sleep_flags: assert property (sleep_instruction && !clear_watchdog_instruction |=>
		core_status_flags[4:3] == 2'h2) else $error("sleep flags wrong");
	a_clear_flags: assert property (clear_watchdog_instruction && !sleep_instruction |=>
		core_status_flags[4:3] == 2'h3) else $error("clear flags wrong");
	a_expiry_clears: assert property (watchdog_timeout |-> !core_status_flags[4])
		else $error("expiry left timeout set");
	a_sw_write_kept: assert property (st_wr && !clear_watchdog_instruction && !sleep_instruction
		&& !watchdog_tick |=> $stable(core_status_flags[4:3])) else $error("reset cause bits written");
	a_bank_addr: assert property (direct_data_addr == {core_status_flags[6:5], direct_addr}
		&& indirect_data_addr == {core_status_flags[7], indirect_ptr}) else $error("bank address wrong");
	c_expiry: cover property (watchdog_timeout);
	c_status_write: cover property (st_wr);
	c_subtract: cover property (alu_op == ALU_SUB);
endmodule : csor_monitor

bind csor_core_regs csor_monitor csor_monitor_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.alu_op, .alu_a, .alu_b, .clear_watchdog_instruction, .sleep_instruction, .watchdog_tick, .direct_addr,
	.indirect_ptr, .direct_data_addr, .indirect_data_addr, .core_status_flags, .watchdog_timeout);

/* test/tb.sv */
// self-checking bench for the core status and option register bank
`timescale 1ns/1ps
module tb;
	import csor_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, core_wr_en = 1'b0, pready, pslverr, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [8:0] core_wr_addr = 9'h000, direct_data_addr, indirect_data_addr;
	logic [7:0] core_wr_data = 8'h00, alu_a = 8'h00, alu_b = 8'h00, core_status_flags, timer_prescale_options;
	csor_alu_op_type alu_op = ALU_NONE;
	logic clear_watchdog_instruction = 1'b0, sleep_instruction = 1'b0, watchdog_enable = 1'b1;
	logic watchdog_tick = 1'b0, instr_cycle_tick = 1'b0, timer0_clock_pin = 1'b0, ext_interrupt_pin = 1'b0;
	logic [5:0] port_a_pullup_mask = 6'h2a, port_a_pullup_en;
	logic [6:0] direct_addr = 7'h05;
	logic [7:0] indirect_ptr = 8'h12;
	logic timer0_increment, watchdog_timeout, ext_int_edge_event;
	int error_cnt = 0, comparisons = 0, wd_cnt = 0, t0_cnt = 0, ext_cnt = 0, t0_base, ext_base;
	csor_alu_op_type op_t[7] = '{ALU_ADD, ALU_ADD, ALU_SUB, ALU_SUB, ALU_ROT_RIGHT, ALU_ROT_LEFT, ALU_LOGIC};
	// operand a, operand b, flag mask, expected flags
	logic [23:0] alu_t[7] = '{24'h0f0172, 24'hff0177, 24'h050577, 24'h030570, 24'h010011, 24'h010010, 24'h000044};

	always #12.5 pclk = ~pclk;

	csor_core_regs #(.WDT_POST_TOP(16'h0003)) csor_core_regs_i (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .core_wr_en, .core_wr_addr, .core_wr_data, .alu_op, .alu_a,
		.alu_b, .clear_watchdog_instruction, .sleep_instruction, .watchdog_enable, .watchdog_tick,
		.instr_cycle_tick, .timer0_clock_pin, .ext_interrupt_pin, .port_a_pullup_mask, .direct_addr,
		.indirect_ptr, .direct_data_addr, .indirect_data_addr, .core_status_flags, .timer_prescale_options,
		.port_a_pullup_en, .timer0_increment, .watchdog_timeout, .ext_int_edge_event);

	always @(posedge pclk) begin
		if (watchdog_timeout === 1'b1) wd_cnt <= wd_cnt + 1;
		if (timer0_increment === 1'b1) t0_cnt <= t0_cnt + 1;
		if (ext_int_edge_event === 1'b1) ext_cnt <= ext_cnt + 1;
	end

	// ****************************************
	// access tasks
	// ****************************************
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask : tick

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// no cycle count assumed; the watchdog cuts a hang short
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic alu(input csor_alu_op_type op, input logic [7:0] a, input logic [7:0] b);
		@(posedge pclk);
		alu_op <= op;
		alu_a <= a;
		alu_b <= b;
		@(posedge pclk);
		alu_op <= ALU_NONE;
		@(posedge pclk);
	endtask : alu

	// 0 clear watchdog, 1 sleep, 2 instruction tick
	task automatic strobe(input int w);
		@(posedge pclk);
		clear_watchdog_instruction <= w == 0;
		sleep_instruction <= w == 1;
		instr_cycle_tick <= w == 2;
		@(posedge pclk);
		{clear_watchdog_instruction, sleep_instruction, instr_cycle_tick} <= 3'h0;
		@(posedge pclk);
	endtask : strobe

	task automatic give_verdict;
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : give_verdict

	initial begin
		#(25 * 4000);
		error_cnt++;
		give_verdict();
	end

	initial begin
		tick(10);
		presetn <= 1'b1;
		apb(1'b0, 12'h00c, 32'h0);
		chk("status reset", rd, 32'h18);
		apb(1'b0, 12'h604, 32'h0);
		chk("option reset", rd, 32'hff);
		for (int b = 0; b < 4; b++) begin
			apb(1'b1, 12'h00c + 12'(b * 512), {b[1], b[1:0], 5'h07});
			apb(1'b0, 12'h00c, 32'h0);
			chk("status bank", rd, {b[1], b[1:0], 5'h1f});
			chk("direct addr", direct_data_addr, {b[1:0], 7'h05});
			chk("indirect addr", indirect_data_addr, {b[1], 8'h12});
		end
		apb(1'b1, 12'h604, 32'h55);
		apb(1'b0, 12'h204, 32'h0);
		chk("option mirror", rd, 32'h55);
		chk("option out", timer_prescale_options, 8'h55);
		tick(2);
		chk("pullups on", port_a_pullup_en, 6'h2a);
		apb(1'b1, 12'h204, 32'hd5);
		tick(2);
		chk("pullups off", port_a_pullup_en, 6'h00);
		apb(1'b0, 12'h008, 32'h0);
		chk("unmapped err", err, 1'b1);
		chk("unmapped data", rd, 32'h0);
		for (int i = 0; i < 7; i++) begin
			alu(op_t[i], alu_t[i][23:16], alu_t[i][15:8]);
			chk("alu flags", {1'b0, core_status_flags[2:0]} & alu_t[i][7:4], alu_t[i][3:0]);
		end
		@(posedge pclk);
		core_wr_en <= 1'b1;
		core_wr_addr <= 9'h103;
		core_wr_data <= 8'h05;
		alu_op <= ALU_ADD;
		alu_a <= 8'h0f;
		alu_b <= 8'h01;
		@(posedge pclk);
		core_wr_en <= 1'b0;
		alu_op <= ALU_NONE;
		@(posedge pclk);
		chk("written flags", core_status_flags, 8'h1a);
		apb(1'b1, 12'h204, 32'h08);
		strobe(0);
		@(posedge pclk);
		watchdog_tick <= 1'b1;
		tick(4);
		watchdog_tick <= 1'b0;
		tick(2);
		chk("expiry count", wd_cnt, 1);
		chk("timeout flag", core_status_flags[4], 1'b0);
		strobe(1);
		chk("sleep flags", core_status_flags[4:3], 2'h2);
		strobe(0);
		chk("clear flags", core_status_flags[4:3], 2'h3);
		t0_base = t0_cnt;
		repeat (3) strobe(2);
		apb(1'b1, 12'h204, 32'h01);
		repeat (8) strobe(2);
		tick(1);
		chk("timer0 ticks", t0_cnt - t0_base, 5);
		for (int k = 0; k < 2; k++) begin
			apb(1'b1, 12'h204, k ? 32'h38 : 32'h68);
			t0_base = t0_cnt;
			ext_base = ext_cnt;
			timer0_clock_pin <= 1'b1;
			ext_interrupt_pin <= 1'b1;
			tick(8);
			chk("rise t0", t0_cnt - t0_base, 1 - k);
			chk("rise int", ext_cnt - ext_base, 1 - k);
			timer0_clock_pin <= 1'b0;
			ext_interrupt_pin <= 1'b0;
			tick(8);
			chk("fall t0", t0_cnt - t0_base, 1);
			chk("fall int", ext_cnt - ext_base, 1);
		end
		give_verdict();
	end
endmodule : tb
